// >>> hw/mpio_core.sv
// Multi-purpose I/O mode selection, state indications and asynchronous access over APB
//
// What this block does
// (R1) Trigger indication goes high on trigger, low when the run ends.
// (R2) In segmented modes outside FIFO mode trigger indication drops at each segment end.
// (R3) In FIFO mode trigger indication stays high until the run stops.
// (R4) Run-state mode shows high while the card runs.
// (R5) Armed mode high only while running, pretrigger done, trigger not seen.
// (R6) Marker mode pulses once per replay pass for half the memory length.
// (R7) Clock mode carries the sampling clock scaled by oversampling factor.
// (R8) Group armed mode high only when every enabled card that has not finished is armed.
// (R9) Finished cards drop out of the group combination; the output is low once all enabled cards finish.
// (R10) Mode writes stay pending until a start or write-setup command.
// (R11) Software puts a line in an async mode before async access.
// (R12) Async input stays readable in trigger-input or digital-input mode.
// (R13) Lines one to three map to async register bits 1 to 3.
// (R14) Async writes and reads act at once, regardless of mode or rate.
// (R15) Reading an output line returns its driven level.
// (R16) Line zero is output only; bit 0 never reflects an input.
// (R17) Software selects exactly one mode per line.
// (R18) Mode code zero disables and tristates a line; default after reset.
// (R19) Code 1 makes an async input, code 2 an async output.
// (R20) External inputs pass a two-stage synchronizer before readback.
`timescale 1ns/1ps
module mpio_core
  import mpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input mpio_pkg::word_t pwdata,
  output mpio_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_event,
  input wire logic run_active,
  input wire logic pretrigger_done,
  input wire logic segment_end,
  input wire logic segmented_mode,
  input wire logic fifo_mode,
  input wire logic cont_replay,
  input wire logic replay_tick,
  input wire logic [3:0] peer_armed,
  input wire logic [3:0] peer_finished,
  input wire logic [3:1] line_in,
  output logic [3:0] line_out,
  output logic [3:0] line_oe
);
  card_state_if st ();

  word_t mode_pend_reg [4];
  line_func_t mode_act_reg [4];
  logic [3:0] async_out_reg;
  word_t memory_length_reg;
  word_t clock_half_reg;
  word_t os_factor_reg;
  logic [3:0] group_enable_reg;
  logic trig_ind_reg;
  logic run_state_reg;
  logic armed_state_reg;
  logic group_armed_reg;
  logic [3:1] in_meta_reg;
  logic [3:1] in_sync_reg;
  logic [3:0] line_out_reg;
  logic [3:0] line_oe_reg;
  word_t prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [3:0] drive_w;
  logic [3:0] oe_w;
  logic [17:0] idx;
  logic setup_done;
  logic access;
  logic wr;
  logic cmd_apply;
  logic [3:0] async_rd;
  logic [3:0] active_mask;
  word_t read_word;
  logic read_hit;
  logic [2:0] slot;

  // Word index; the low two address bits are ignored
  assign idx = paddr[19:2];
  // One wait state: pready rises in the second access cycle
  assign setup_done = psel && penable && !pready_reg;
  assign access = psel && penable && pready_reg;
  assign wr = access && pwrite;

  // Mode register number for an index, 4 when not a mode register
  function automatic logic [2:0] mode_slot(logic [17:0] i);
    case (i)
      `IDX_LINE_ZERO_MODE: mode_slot = 3'h0;
      `IDX_LINE_ONE_MODE: mode_slot = 3'h1;
      `IDX_LINE_TWO_MODE: mode_slot = 3'h2;
      `IDX_LINE_THREE_MODE: mode_slot = 3'h3;
      default: mode_slot = 3'h4;
    endcase
  endfunction

  assign slot = mode_slot(idx);
  assign cmd_apply = wr && (idx == `IDX_CARD_COMMAND) &&
    (pwdata[`CMD_CARD_START_BIT] || pwdata[`CMD_CARD_WRITE_SETUP_BIT]);

  // Pending mode values, visible on readback before they take effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        mode_pend_reg[i] <= `RST_MODE; // (R18)
      end
    end else if (wr && slot != 3'h4) begin
      mode_pend_reg[slot[1:0]] <= pwdata; // (R10)
    end
  end

  // Active modes change only on a start or write-setup command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        mode_act_reg[i] <= line_off; // (R18)
      end
    end else if (cmd_apply) begin
      for (int i = 0; i < 4; i++) begin
        mode_act_reg[i] <= decode_mode(mode_pend_reg[i]); // (R10) (R19)
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_out_reg <= `RST_ASYNC_LINE_IO;
    end else if (wr && idx == `IDX_ASYNC_LINE_IO) begin
      async_out_reg <= pwdata[3:0]; // (R13) (R14) (R16)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_length_reg <= `RST_MEMORY_LENGTH;
      clock_half_reg <= `RST_CLOCK_HALF_PERIOD;
      os_factor_reg <= `RST_OVERSAMPLING_FACTOR;
      group_enable_reg <= `RST_GROUP_ENABLE;
    end else if (wr) begin
      case (idx)
        `IDX_MEMORY_LENGTH: memory_length_reg <= pwdata;
        `IDX_CLOCK_HALF_PERIOD: clock_half_reg <= pwdata;
        `IDX_OVERSAMPLING_FACTOR: os_factor_reg <= pwdata;
        `IDX_GROUP_ENABLE: group_enable_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Trigger indication; a new trigger wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ind_reg <= 1'b0;
    end else if (trigger_event && run_active) begin
      trig_ind_reg <= 1'b1; // (R1)
    end else if (!run_active) begin
      trig_ind_reg <= 1'b0; // (R1) (R3)
    end else if (segmented_mode && !fifo_mode && segment_end) begin
      trig_ind_reg <= 1'b0; // (R2)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_state_reg <= 1'b0;
      armed_state_reg <= 1'b0;
    end else begin
      run_state_reg <= run_active; // (R4)
      armed_state_reg <= run_active && pretrigger_done && !trig_ind_reg
        && !trigger_event; // (R5)
    end
  end

  // Cards still running within the enabled group
  assign active_mask = group_enable_reg & ~peer_finished; // (R9)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_armed_reg <= 1'b0;
    end else begin
      group_armed_reg <= (|active_mask) && ((active_mask & ~peer_armed) == 4'h0); // (R8) (R9)
    end
  end

  assign st.trig_ind = trig_ind_reg;
  assign st.run_state = run_state_reg;
  assign st.armed_state = armed_state_reg;
  assign st.group_armed = group_armed_reg;

  wave_gen u_wave (
    .pclk(pclk),
    .presetn(presetn),
    .run_active(run_active),
    .cont_replay(cont_replay),
    .replay_tick(replay_tick),
    .memory_length(memory_length_reg),
    .clock_half(clock_half_reg),
    .os_factor(os_factor_reg),
    .st(st.gen)
  );

  generate
    for (genvar g = 0; g < 4; g++) begin : g_line
      line_mux u_mux (
        .func(mode_act_reg[g]),
        .async_bit(async_out_reg[g]),
        .st(st.line),
        .drive(drive_w[g]),
        .oe(oe_w[g])
      );
    end
  endgenerate

  // Line zero never drives an input path, so only its output stage exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_out_reg <= 4'h0;
      line_oe_reg <= 4'h0; // (R18)
    end else begin
      line_out_reg <= drive_w;
      line_oe_reg <= oe_w;
    end
  end

  // Inputs are sampled in every mode, so trigger and digital inputs read back too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta_reg <= 3'h0;
      in_sync_reg <= 3'h0;
    end else begin
      in_meta_reg <= line_in; // (R20)
      in_sync_reg <= in_meta_reg; // (R12) (R20)
    end
  end

  // Driven lines read their own level, undriven lines 1 to 3 the synchronized pin, undriven line 0 zero
  always_comb begin
    async_rd[0] = line_oe_reg[0] & line_out_reg[0]; // (R16)
    for (int i = 1; i < 4; i++) begin
      async_rd[i] = line_oe_reg[i] ? line_out_reg[i] : in_sync_reg[i]; // (R13) (R15)
    end
  end

  always_comb begin
    read_word = 32'h0;
    read_hit = 1'b1;
    if (slot != 3'h4) begin
      read_word = mode_pend_reg[slot[1:0]];
    end else begin
      case (idx)
        `IDX_ASYNC_LINE_IO: read_word = {28'h0, async_rd}; // (R14)
        `IDX_CARD_COMMAND: read_word = 32'h0;
        `IDX_MEMORY_LENGTH: read_word = memory_length_reg;
        `IDX_CLOCK_HALF_PERIOD: read_word = clock_half_reg;
        `IDX_OVERSAMPLING_FACTOR: read_word = os_factor_reg;
        `IDX_GROUP_ENABLE: read_word = {28'h0, group_enable_reg};
        `IDX_LINE_STATUS: read_word = {20'h0, line_oe_reg, line_out_reg, group_armed_reg,
          armed_state_reg, run_state_reg, trig_ind_reg};
        default: read_hit = 1'b0;
      endcase
    end
  end

  // APB answer: registered ready, data and error, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_done;
    end
  end

  // Read data stands only with pready, so a stale word never lingers on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (setup_done && !pwrite) begin
      prdata_reg <= read_word;
    end else begin
      prdata_reg <= 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup_done && !read_hit;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign line_out = line_out_reg;
  assign line_oe = line_oe_reg;
endmodule // mpio_core

// >>> hw/mpio_regs.svh
// Register indices, mode codes, reset values and command bits of the multi-purpose I/O block
`ifndef MPIO_REGS_SVH
`define MPIO_REGS_SVH

`define IDX_LINE_ZERO_MODE 18'd47200
`define IDX_LINE_ONE_MODE 18'd47201
`define IDX_LINE_TWO_MODE 18'd47202
`define IDX_LINE_THREE_MODE 18'd47203
`define IDX_ASYNC_LINE_IO 18'd47220
`define IDX_CARD_COMMAND 18'd47230
`define IDX_MEMORY_LENGTH 18'd47231
`define IDX_CLOCK_HALF_PERIOD 18'd47232
`define IDX_OVERSAMPLING_FACTOR 18'd47233
`define IDX_GROUP_ENABLE 18'd47234
`define IDX_LINE_STATUS 18'd47235

`define LINE_DISABLED_MODE 32'h00000000
`define ASYNC_INPUT_MODE 32'h00000001
`define ASYNC_OUTPUT_MODE 32'h00000002
`define SYNC_DIGITAL_INPUT_MODE 32'h00000004
`define EXTRA_TRIGGER_INPUT_MODE 32'h00000010
`define TRIGGER_INDICATE_MODE 32'h00000020
`define RUN_STATE_MODE 32'h00000100
`define ARMED_STATE_MODE 32'h00000200
`define CONTINUOUS_MARKER_MODE 32'h00002000
`define SAMPLE_CLOCK_OUT_MODE 32'h00008000
`define GROUP_ARMED_STATE_MODE 32'h00010000

`define CMD_CARD_START_BIT 0
`define CMD_CARD_WRITE_SETUP_BIT 1

`define RST_MODE 32'h00000000
`define RST_ASYNC_LINE_IO 4'h0
`define RST_MEMORY_LENGTH 32'h00000400
`define RST_CLOCK_HALF_PERIOD 32'h00000001
`define RST_OVERSAMPLING_FACTOR 32'h00000001
`define RST_GROUP_ENABLE 4'h1

`endif

// >>> hw/mpio_pkg.sv
// Types and mode decoding shared by the multi-purpose I/O modules
package mpio_pkg;
  `include "mpio_regs.svh"

  typedef logic [31:0] word_t;

  typedef enum {
    line_off, line_async_in, line_async_out, line_trig_in, line_dig_in, line_trig_ind,
    line_run, line_armed, line_marker, line_clock, line_group_armed
  } line_func_t;

  // Anything that is not exactly one known code leaves the line off
  function automatic line_func_t decode_mode(word_t code);
    case (code)
      `ASYNC_INPUT_MODE: decode_mode = line_async_in;
      `ASYNC_OUTPUT_MODE: decode_mode = line_async_out;
      `EXTRA_TRIGGER_INPUT_MODE: decode_mode = line_trig_in;
      `SYNC_DIGITAL_INPUT_MODE: decode_mode = line_dig_in;
      `TRIGGER_INDICATE_MODE: decode_mode = line_trig_ind;
      `RUN_STATE_MODE: decode_mode = line_run;
      `ARMED_STATE_MODE: decode_mode = line_armed;
      `CONTINUOUS_MARKER_MODE: decode_mode = line_marker;
      `SAMPLE_CLOCK_OUT_MODE: decode_mode = line_clock;
      `GROUP_ARMED_STATE_MODE: decode_mode = line_group_armed;
      default: decode_mode = line_off;
    endcase
  endfunction
endpackage

// >>> hw/card_state_if.sv
// Card state signals shared between the core, the waveform generator and the line muxes
`timescale 1ns/1ps
interface card_state_if;
  logic trig_ind;
  logic run_state;
  logic armed_state;
  logic group_armed;
  logic marker;
  logic sample_clk;

  modport core (output trig_ind, output run_state, output armed_state, output group_armed);
  modport gen (output marker, output sample_clk);
  modport line (input trig_ind, input run_state, input armed_state, input group_armed,
    input marker, input sample_clk);
endinterface

// >>> hw/line_mux.sv
// Output selector of one multi-purpose line
`timescale 1ns/1ps
module line_mux
  import mpio_pkg::*;
(
  input mpio_pkg::line_func_t func,
  input wire logic async_bit,
  card_state_if.line st,
  output logic drive,
  output logic oe
);
  always_comb begin
    drive = 1'b0;
    oe = 1'b1;
    case (func)
      line_async_out: drive = async_bit; // (R19)
      line_trig_ind: drive = st.trig_ind; // (R1)
      line_run: drive = st.run_state; // (R4)
      line_armed: drive = st.armed_state; // (R5)
      line_marker: drive = st.marker; // (R6)
      line_clock: drive = st.sample_clk; // (R7)
      line_group_armed: drive = st.group_armed; // (R8)
      default: oe = 1'b0; // (R18)
    endcase
  end
endmodule // line_mux

// >>> hw/wave_gen.sv
// Continuous replay marker and sampling clock generator
`timescale 1ns/1ps
module wave_gen
  import mpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_active,
  input wire logic cont_replay,
  input wire logic replay_tick,
  input mpio_pkg::word_t memory_length,
  input mpio_pkg::word_t clock_half,
  input mpio_pkg::word_t os_factor,
  card_state_if.gen st
);
  word_t pos_reg;
  word_t acc_reg;
  word_t step;
  logic marker_reg;
  logic clk_reg;

  // Factor 0 is treated as 1 so the clock never freezes
  assign step = (os_factor == 32'h0) ? 32'h1 : os_factor;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= 32'h0;
    end else if (!(run_active && cont_replay)) begin
      pos_reg <= 32'h0;
    end else if (replay_tick) begin
      pos_reg <= (pos_reg + 32'h1 >= memory_length) ? 32'h0 : pos_reg + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marker_reg <= 1'b0;
    end else begin
      marker_reg <= run_active && cont_replay && (pos_reg < (memory_length >> 1)); // (R6)
    end
  end

  // Oversampling scales the rate by stepping the phase accumulator faster
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 32'h0;
      clk_reg <= 1'b0;
    end else if (acc_reg + step >= clock_half) begin
      acc_reg <= 32'h0;
      clk_reg <= ~clk_reg; // (R7)
    end else begin
      acc_reg <= acc_reg + step;
    end
  end

  assign st.marker = marker_reg;
  assign st.sample_clk = clk_reg;
endmodule // wave_gen

// >>> bench/ext_equip.sv
// Model of the equipment wired to the multi-purpose connectors
`timescale 1ns/1ps
module ext_equip (
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe,
  input wire logic [3:1] ext_lvl,
  output logic [3:1] line_in
);
  // Wire level resolved from both parties; a driving card wins
  always_comb begin
    for (int i = 1; i < 4; i++) begin
      line_in[i] = line_oe[i] ? line_out[i] : ext_lvl[i];
    end
  end
endmodule // ext_equip

// >>> bench/mpio_core_monitor.sv
// Assertions on the ports of the multi-purpose I/O block
`timescale 1ns/1ps
`include "mpio_regs.svh"
module mpio_core_monitor
  import mpio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input mpio_pkg::word_t pwdata,
  input mpio_pkg::word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cmd_done;
  logic async_rd;
  assign cmd_done = psel && penable && pready && pwrite
    && paddr[19:2] == `IDX_CARD_COMMAND && pwdata[1:0] != 2'b00;
  assign async_rd = pready && !pwrite && paddr[19:2] == `IDX_ASYNC_LINE_IO;
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  a_reset_lines_off: assert property ($rose(presetn) |-> line_oe == 4'h0)
    else $error("line driven after reset");
  // Line state held steady so the read sees one value
  a_async_read_out: assert property (async_rd && $stable(line_out) && $stable(line_oe)
    |-> (prdata[3:1] & line_oe[3:1]) == (line_out[3:1] & line_oe[3:1]))
    else $error("driven level not read back");
  a_bit0_out_only: assert property (async_rd && $stable(line_out) && $stable(line_oe)
    |-> prdata[0] == (line_out[0] & line_oe[0]))
    else $error("bit 0 not the driven level");
  a_upper_bits_zero: assert property (async_rd |-> prdata[31:4] == 28'h0)
    else $error("async read upper bits set");
  a_mode_pending: assert property ($changed(line_oe) |-> $past(cmd_done, 2))
    else $error("line mode changed without command");
  c_cmd: cover property (cmd_done);
  c_async_rd: cover property (async_rd);
  c_err: cover property (pslverr);
endmodule // mpio_core_monitor

bind mpio_core mpio_core_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .line_out, .line_oe);

// >>> bench/multipurpose_io_mode_select_tb_top.sv
// Testbench of the multi-purpose I/O block
`timescale 1ns/1ps
`include "mpio_regs.svh"
module multipurpose_io_mode_select_tb_top;
  import mpio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic trigger_event, run_active, pretrigger_done, segment_end;
  logic segmented_mode, fifo_mode, cont_replay, replay_tick;
  logic [19:0] paddr;
  word_t pwdata, prdata, rd;
  logic [3:0] peer_armed, peer_finished, line_out, line_oe;
  logic [3:1] line_in, ext_lvl;
  int err_count, num_checks, n;
  mpio_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trigger_event, .run_active, .pretrigger_done, .segment_end,
    .segmented_mode, .fifo_mode, .cont_replay, .replay_tick, .peer_armed, .peer_finished,
    .line_in, .line_out, .line_oe);
  ext_equip ext_u (.line_out, .line_oe, .ext_lvl, .line_in);
  always #20 pclk = ~pclk;
  task automatic chk(input word_t got, input word_t exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle edge after each transfer so psel never flips twice in one step
  task automatic apb(input logic wr, input logic [17:0] idx, input word_t wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [17:0] idx, input word_t d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [17:0] idx, input word_t e);
    apb(1'b0, idx, 32'h0);
    chk(rd, e);
  endtask
  task automatic set_mode(input int ln, input word_t code);
    wr(`IDX_LINE_ZERO_MODE + 18'(ln), code);
    wr(`IDX_CARD_COMMAND, 32'h2);
    repeat (2) @(posedge pclk);
  endtask
  task automatic exp3(input logic e);
    repeat (3) @(posedge pclk);
    chk({31'h0, line_out[3]}, {31'h0, e});
  endtask
  task automatic pulse(input logic seg);
    if (seg) segment_end <= 1'b1;
    else trigger_event <= 1'b1;
    @(posedge pclk);
    segment_end <= 1'b0;
    trigger_event <= 1'b0;
  endtask
  task automatic count16(input logic edges);
    logic prev;
    n = 0;
    repeat (4) @(posedge pclk);
    prev = line_out[3];
    repeat (16) begin
      @(posedge pclk);
      n += edges ? int'(line_out[3] !== prev) : int'(line_out[3] === 1'b1);
      prev = line_out[3];
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, trigger_event, run_active} = '0;
    {pretrigger_done, segment_end, segmented_mode, fifo_mode, cont_replay} = '0;
    {replay_tick, peer_armed, peer_finished, ext_lvl} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rdc(`IDX_LINE_ZERO_MODE + 18'(i), `RST_MODE);
    chk({28'h0, line_oe}, 32'h0);
    apb(1'b0, 18'h3ffff, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    wr(`IDX_LINE_ZERO_MODE, `ASYNC_OUTPUT_MODE);
    wr(`IDX_LINE_ONE_MODE, `ASYNC_INPUT_MODE);
    wr(`IDX_LINE_TWO_MODE, `ASYNC_OUTPUT_MODE);
    wr(`IDX_LINE_THREE_MODE, `TRIGGER_INDICATE_MODE);
    chk({28'h0, line_oe}, 32'h0);
    wr(`IDX_CARD_COMMAND, 32'h1);
    repeat (2) @(posedge pclk);
    chk({28'h0, line_oe}, 32'hd);
    ext_lvl <= 3'b001;
    wr(`IDX_ASYNC_LINE_IO, 32'h5);
    repeat (2) @(posedge pclk);
    chk({28'h0, line_out & line_oe}, 32'h5);
    rdc(`IDX_ASYNC_LINE_IO, 32'h7);
    ext_lvl <= 3'b000;
    wr(`IDX_ASYNC_LINE_IO, 32'h1);
    set_mode(0, `LINE_DISABLED_MODE);
    rdc(`IDX_ASYNC_LINE_IO, 32'h0);
    ext_lvl <= 3'b001;
    set_mode(1, `EXTRA_TRIGGER_INPUT_MODE);
    rdc(`IDX_ASYNC_LINE_IO, 32'h2);
    set_mode(1, `SYNC_DIGITAL_INPUT_MODE);
    rdc(`IDX_ASYNC_LINE_IO, 32'h2);
    set_mode(2, 32'h3);
    chk({31'h0, line_oe[2]}, 32'h0);
    $display("test async done");
    run_active <= 1'b1;
    pulse(1'b0);
    exp3(1'b1);
    segmented_mode <= 1'b1;
    pulse(1'b1);
    exp3(1'b0);
    fifo_mode <= 1'b1;
    pulse(1'b0);
    pulse(1'b1);
    exp3(1'b1);
    run_active <= 1'b0;
    exp3(1'b0);
    $display("test trigger done");
    set_mode(3, `RUN_STATE_MODE);
    exp3(1'b0);
    run_active <= 1'b1;
    exp3(1'b1);
    set_mode(3, `ARMED_STATE_MODE);
    exp3(1'b0);
    pretrigger_done <= 1'b1;
    exp3(1'b1);
    pulse(1'b0);
    exp3(1'b0);
    $display("test state done");
    set_mode(3, `GROUP_ARMED_STATE_MODE);
    wr(`IDX_GROUP_ENABLE, 32'h3);
    peer_armed <= 4'h1;
    exp3(1'b0);
    peer_armed <= 4'h3;
    exp3(1'b1);
    peer_armed <= 4'h1;
    peer_finished <= 4'h2;
    exp3(1'b1);
    peer_finished <= 4'h3;
    exp3(1'b0);
    $display("test group done");
    wr(`IDX_CLOCK_HALF_PERIOD, 32'h4);
    set_mode(3, `SAMPLE_CLOCK_OUT_MODE);
    for (int f = 1; f < 3; f++) begin
      wr(`IDX_OVERSAMPLING_FACTOR, word_t'(f));
      count16(1'b1);
      chk(word_t'(n), word_t'(4 * f));
    end
    wr(`IDX_MEMORY_LENGTH, 32'h8);
    {cont_replay, replay_tick} <= 2'b11;
    set_mode(3, `CONTINUOUS_MARKER_MODE);
    count16(1'b0);
    chk(word_t'(n), 32'h8);
    $display("test generator done");
    print_verdict();
  end
endmodule // multipurpose_io_mode_select_tb_top
